/* File: rtl/flash_factory_program_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
// Function
// R1: double program: setup, word, word starts
// R2: programming bank reads return status
// R3: busy bank takes only read commands
// R4: no suspend, no other bank ops
// R5: reset aborts program in progress
// R6: quad program: setup, four words, start
// R7: host limits streamed cycles per block
// R8: stream entry: setup then confirm, status reads
// R9: host never writes read-status during stream
// R10: stream: same address increments, new jumps
// R11: out-of-block ffff ends program pass
// R12: host polls bank write status per word
// R13: verify resends words, compares, ffff ends
// R14: verify done keeps status mode, errors reported
// R15: exit sets controller ready bit
// R16: paged: four-word pages, auto verify
// R17: paged entry single setup, status reads
// R18: page load four words, first address checked
// R19: later page same block, ffff exits
// R20: host checks ready after first word
// R21: paged verify: ready zero, write status one
// R22: paged end: ready one, write status zero
// R23: setup accepts any address in bank
// R24: ready bit zero while controller active
// R25: host reads status between data writes
// R26: track sequence, phase and start block
module flash_factory_program_sequencer
	import fps_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_i,
	// host bus write
	input  wire logic                   wr_i,
	input  wire bus_word_t              wr_word_i,
	// host bus read
	input  wire logic                   rd_i,
	input  wire logic [`FPS_ADDR_W-1:0] rd_addr_i,
	output logic                        rd_status_sel_o,
	output read_mode_t                  read_mode_o,
	// program/erase controller
	output pec_req_t                    pec_req_o,
	output bus_word_t                   page_word_o [4],
	input  wire logic                   pec_busy_i,
	input  wire logic                   pec_fail_i,
	// device-wide arbitration
	input  wire logic                   suspend_req_i,
	output logic                        suspend_refused_o,
	output logic                        other_bank_block_o,
	// status
	output logic [7:0]                  status_o
);
	typedef enum logic [3:0] {
		idle,
		dbl_word,
		quad_word,
		par_busy,
		strm_confirm,
		strm_prog,
		strm_verify,
		page_first,
		page_load,
		page_pv,
		done_status
	} seq_t;

	seq_t                       state;
	seq_t                       next_state;
	logic [`FPS_ADDR_W-1:0]     start_addr;
	logic [`FPS_ADDR_W-1:0]     word_ptr;
	logic [2:0]                 word_cnt;
	logic                       fail_seen;
	logic                       pv_running;
	logic                       page_load_en;
	logic [1:0]                 page_idx;
	logic [`FPS_ADDR_W-1:0]     busy_bank;
	read_mode_t                 read_mode;

	logic [7:0]                 wr_cmd;
	logic                       same_block;
	logic                       term_write;
	logic                       in_seq;
	logic                       is_read_cmd;

	assign wr_cmd      = wr_word_i.data[7:0];
	assign same_block  = wr_word_i.addr[`FPS_ADDR_W-1:`FPS_BLOCK_LSB] ==
		start_addr[`FPS_ADDR_W-1:`FPS_BLOCK_LSB];
	assign term_write  = !same_block && wr_word_i.data == `FPS_TERM_DATA;
	assign is_read_cmd = wr_cmd == `FPS_CMD_RD_ARRAY ||
		wr_cmd == `FPS_CMD_RD_STAT || wr_cmd == `FPS_CMD_RD_SIG ||
		wr_cmd == `FPS_CMD_RD_QUERY;
	assign in_seq      = state != idle && state != done_status;

	////////////////////////////////////////////////////////////////////////
	// sequence and phase tracking
	always_comb begin
		next_state = state;
		unique case (state)
			idle, done_status: begin
				if (wr_i) begin
					// setup accepts any address, bank latched below
					unique case (wr_cmd) // R23
						`FPS_CMD_DOUBLE: next_state = dbl_word; // R1
						`FPS_CMD_QUAD:   next_state = quad_word; // R6
						`FPS_CMD_STREAM: next_state = strm_confirm; // R8
						`FPS_CMD_PAGED:  next_state = page_first; // R17
						default:         next_state = state;
					endcase
				end
			end
			dbl_word: begin
				if (wr_i && word_cnt == 3'd1)
					next_state = par_busy; // R1
			end
			quad_word: begin
				if (wr_i && word_cnt == 3'd3)
					next_state = par_busy; // R6
			end
			par_busy: begin
				// busy rises only one edge after the start pulse
				if (!pec_busy_i && !pec_req_o.start)
					next_state = done_status;
			end
			strm_confirm: begin
				// a bad confirm drops the command
				if (wr_i)
					next_state = wr_cmd == `FPS_CMD_CONFIRM ? strm_prog
						: done_status; // R8
			end
			strm_prog: begin
				if (wr_i && term_write && word_cnt != 3'd0)
					next_state = strm_verify; // R11
			end
			strm_verify: begin
				if (wr_i && term_write && word_cnt != 3'd0)
					next_state = done_status; // R13 R14
			end
			page_first: begin
				// other-block writes other than ffff are ignored while idle between pages
				if (wr_i && term_write && pv_running == 1'b0 &&
					word_cnt == 3'd0 && start_addr != '0)
					next_state = done_status; // R19
				else if (wr_i && !pv_running && (same_block ||
					start_addr == '0))
					next_state = page_load; // R18
			end
			page_load: begin
				if (wr_i && word_cnt == 3'd3)
					next_state = page_pv; // R18
			end
			page_pv: begin
				if (!pec_busy_i && !pec_req_o.start)
					next_state = page_first; // R16
			end
			default: next_state = idle;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= idle; // R5
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start address, word pointer and word count
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			start_addr <= '0;
			word_ptr   <= '0;
			word_cnt   <= 3'd0;
		end else if (wr_i) begin
			unique case (state)
				idle, done_status: begin
					start_addr <= next_state == page_first ? '0
						: wr_word_i.addr; // R26
					word_cnt   <= 3'd0;
				end
				dbl_word, quad_word, page_load: begin
					word_cnt <= next_state == state ?
						word_cnt + 3'd1 : 3'd0;
				end
				strm_confirm: begin
					start_addr <= '0;
					word_cnt   <= 3'd0;
				end
				strm_prog, strm_verify: begin
					if (next_state != state) begin
						word_cnt <= 3'd0;
					end else if (same_block || word_cnt == 3'd0) begin // R11
						if (word_cnt == 3'd0) begin
							start_addr <= wr_word_i.addr; // R26
							word_ptr   <= wr_word_i.addr;
						end else if (wr_word_i.addr == start_addr) begin
							word_ptr <= word_ptr + 1'b1; // R10
						end else begin
							word_ptr <= wr_word_i.addr; // R10
						end
						word_cnt <= 3'd1;
					end
				end
				page_first: begin
					if (next_state == page_load) begin
						if (start_addr == '0)
							start_addr <= wr_word_i.addr; // R26
						word_cnt <= 3'd1;
					end
				end
				default: begin
				end
			endcase
		end else if (state == par_busy || state == page_pv) begin
			word_cnt <= 3'd0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer, only the slot index matters after the first word
	assign page_load_en = wr_i && (state == dbl_word || state == quad_word ||
		state == page_load || next_state == page_load);
	assign page_idx     = state == page_first ? 2'd0 : word_cnt[1:0]; // R18

	for (genvar s = 0; s < 4; s++) begin : g_slot
		fps_page_slot #(
			.SLOT (2'(s))
		) u_slot (
			.clk_sys_i (clk_sys_i),
			.rst_i     (rst_i),
			.load_i    (page_load_en),
			.index_i   (page_idx),
			.word_i    (wr_word_i),
			.word_o    (page_word_o[s])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// controller requests, one pulse per double/quad program, stream word or page
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pec_req_o  <= '0;
			pv_running <= 1'b0;
		end else begin
			pec_req_o.start <= 1'b0;
			if (next_state == par_busy && state != par_busy)
				pec_req_o.start <= 1'b1; // R1 R6
			if (next_state == page_pv && state == page_load) begin
				pec_req_o.start  <= 1'b1; // R16
				pec_req_o.verify <= 1'b1;
				pv_running       <= 1'b1;
			end
			if (state == page_pv && !pec_busy_i && !pec_req_o.start)
				pv_running <= 1'b0; // R21
			if (wr_i && (state == strm_prog || state == strm_verify) &&
				next_state == state && (same_block || word_cnt == 3'd0)) begin
				pec_req_o.start  <= 1'b1;
				pec_req_o.verify <= state == strm_verify; // R13
				pec_req_o.data   <= wr_word_i.data;
				pec_req_o.addr   <= word_cnt == 3'd0 ? wr_word_i.addr
					: (wr_word_i.addr == start_addr ? word_ptr + 1'b1
					: wr_word_i.addr); // R10
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mode of the bank; busy bank only takes read commands
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			read_mode <= rd_array;
			busy_bank <= '0;
		end else if (wr_i) begin
			if ((state == idle || state == done_status) &&
				next_state != state) begin
				read_mode <= rd_status; // R2 R8 R17
				busy_bank <= wr_word_i.addr;
			end else if ((state == par_busy || state == done_status ||
				state == idle) && is_read_cmd) begin
				// other commands ignored while busy
				unique case (wr_cmd) // R3
					`FPS_CMD_RD_ARRAY: read_mode <= rd_array;
					`FPS_CMD_RD_STAT:  read_mode <= rd_status;
					`FPS_CMD_RD_SIG:   read_mode <= rd_signature;
					default:           read_mode <= rd_query;
				endcase
			end else if (state == page_first &&
				next_state == done_status) begin
				read_mode <= fail_seen ? rd_status : rd_array; // R22
			end
		end
	end

	// stream and paged phases force status on every read
	assign rd_status_sel_o = rd_i && (state inside {strm_confirm, strm_prog,
		strm_verify, page_first, page_load, page_pv} || // R8 R17
		(state == par_busy && rd_addr_i[`FPS_ADDR_W-1:`FPS_BANK_LSB] ==
		busy_bank[`FPS_ADDR_W-1:`FPS_BANK_LSB]) || // R2
		read_mode == rd_status); // R14
	assign read_mode_o = read_mode;

	////////////////////////////////////////////////////////////////////////
	// suspend refusal and dual-operation lockout
	assign other_bank_block_o = in_seq; // R4
	assign suspend_refused_o  = in_seq && suspend_req_i; // R4

	////////////////////////////////////////////////////////////////////////
	// status: sticky failure, ready and bank write status
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			fail_seen <= 1'b0;
		end else if (pec_fail_i && in_seq) begin
			fail_seen <= 1'b1; // R14 R22
		end else if ((state == idle || state == done_status) &&
			next_state != state) begin
			fail_seen <= 1'b0;
		end
	end

	always_comb begin
		status_o = 8'h00;
		// ready only when no sequence holds the controller
		status_o[`FPS_SR_READY]    = !in_seq && !pec_busy_i; // R15 R22 R24
		status_o[`FPS_SR_PROG_ERR] = fail_seen; // R14
		status_o[`FPS_SR_BANK_WS]  = state == page_pv || pv_running ||
			(in_seq && (pec_busy_i || pec_req_o.start)); // R21 R12
	end
endmodule
`default_nettype wire

/* File: rtl/fps_params.svh */
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH
`define FPS_ADDR_W       22
`define FPS_DATA_W       16
`define FPS_BANK_LSB     18
`define FPS_BLOCK_LSB    15
`define FPS_CMD_DOUBLE   8'h35
`define FPS_CMD_QUAD     8'h56
`define FPS_CMD_STREAM   8'h30
`define FPS_CMD_CONFIRM  8'hd0
`define FPS_CMD_PAGED    8'h75
`define FPS_CMD_RD_ARRAY 8'hff
`define FPS_CMD_RD_STAT  8'h70
`define FPS_CMD_RD_SIG   8'h90
`define FPS_CMD_RD_QUERY 8'h98
`define FPS_TERM_DATA    16'hffff
`define FPS_PAGE_WORDS   3'd4
`define FPS_SR_READY     7
`define FPS_SR_PROG_ERR  4
`define FPS_SR_BANK_WS   0
`endif

/* File: rtl/fps_pkg.sv */
`include "fps_params.svh"
package fps_pkg;
	typedef struct packed {
		logic [`FPS_ADDR_W-1:0] addr;
		logic [`FPS_DATA_W-1:0] data;
	} bus_word_t;
	typedef struct packed {
		logic                   start;
		logic                   verify;
		logic [`FPS_ADDR_W-1:0] addr;
		logic [`FPS_DATA_W-1:0] data;
	} pec_req_t;
	typedef enum logic [1:0] {
		rd_array,
		rd_status,
		rd_signature,
		rd_query
	} read_mode_t;
endpackage

/* File: rtl/fps_page_slot.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
// one word slot of the parallel page buffer
module fps_page_slot
	import fps_pkg::*;
#(
	parameter logic [1:0] SLOT = 2'd0
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_i,
	input  wire logic                   load_i,
	input  wire logic [1:0]             index_i,
	input  wire bus_word_t              word_i,
	output bus_word_t                   word_o
);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			word_o <= '0;
		end else if (load_i && index_i == SLOT) begin
			word_o <= word_i;
		end
	end
endmodule
`default_nettype wire

/* File: dv/fps_checker_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
module fps_checker
	import fps_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	// watched ports
	input wire logic        wr_i,
	input wire bus_word_t   wr_word_i,
	input wire logic        rd_i,
	input wire logic [21:0] rd_addr_i,
	input wire logic        rd_status_sel_o,
	input wire read_mode_t  read_mode_o,
	input wire pec_req_t    pec_req_o,
	input wire logic        pec_busy_i,
	input wire logic        suspend_req_i,
	input wire logic        suspend_refused_o,
	input wire logic        other_bank_block_o,
	input wire logic [7:0]  status_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence pulse_s;
		pec_req_o.start ##1 !pec_req_o.start;
	endsequence
	start_single_a: assert property (pec_req_o.start |-> pulse_s)
		else $error("start too long");
	start_cause_a: assert property (pec_req_o.start |-> $past(wr_i))
		else $error("start without write");
	busy_ready_a: assert property (pec_busy_i |-> !status_o[7])
		else $error("ready while busy");
	idle_ready_a: assert property (!pec_busy_i && !other_bank_block_o
		|-> status_o[7] && !status_o[0]) else $error("idle status");
	suspend_a: assert property (suspend_req_i && other_bank_block_o
		|-> suspend_refused_o) else $error("suspend taken");
	bank_stat_a: assert property (pec_busy_i && rd_i
		&& rd_addr_i[21:18] == pec_req_o.addr[21:18] |-> rd_status_sel_o)
		else $error("array read in busy bank");
	busy_ws_a: assert property (pec_busy_i && other_bank_block_o
		|-> status_o[0]) else $error("write status low");
	cmd_ignore_a: assert property (pec_busy_i && wr_i
		&& wr_word_i.data[7:0] == 8'h50
		|=> $stable(read_mode_o) && !pec_req_o.start)
		else $error("command taken while busy");
endmodule
`default_nettype wire

/* File: dv/pec_model.sv */
`timescale 1ns/10ps
`default_nettype none
// controller with fixed busy time; no real array behind it
module pec_model #(
	parameter int LAT = 30
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// requests and answers
	input  wire logic start_i,
	input  wire logic fail_en_i,
	output logic      busy_o,
	output logic      fail_o
);
	logic [7:0] cnt;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			cnt <= 8'h00;
		else if (start_i)
			cnt <= 8'(LAT);
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	// failure only in the last busy cycle, like a final verify
	assign busy_o = (cnt != 8'h00);
	assign fail_o = fail_en_i && (cnt == 8'h01);
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
module tb
	import fps_pkg::*;
;
	localparam logic [21:0] w0 = 22'h0c8000;
	localparam logic [21:0] wb = 22'h0d8000;
	localparam logic [21:0] wx = 22'h0d0000;
	localparam logic [7:0]  rc [4] = '{8'hff, 8'h70, 8'h90, 8'h98};
	logic       clk_sys_i, rst_i, wr_i, rd_i, pec_busy_i, pec_fail_i;
	logic       suspend_req_i, rd_status_sel_o, suspend_refused_o;
	logic       other_bank_block_o, fail_en, st;
	logic [21:0] rd_addr_i;
	logic [7:0] status_o;
	logic [15:0] d [6];
	bus_word_t  wr_word_i;
	bus_word_t  page_word_o [4];
	pec_req_t   pec_req_o;
	read_mode_t read_mode_o, m;
	int         fail_count, compares, cyc;
	flash_factory_program_sequencer dut (
		.clk_sys_i, .rst_i, .wr_i, .wr_word_i, .rd_i, .rd_addr_i,
		.rd_status_sel_o, .read_mode_o, .pec_req_o, .page_word_o,
		.pec_busy_i, .pec_fail_i, .suspend_req_i, .suspend_refused_o,
		.other_bank_block_o, .status_o);
	pec_model #(.LAT(30)) pec (.clk_sys_i, .rst_i,
		.start_i(pec_req_o.start), .fail_en_i(fail_en),
		.busy_o(pec_busy_i), .fail_o(pec_fail_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out;
		end
	end
	task close_out;
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic ok, input string s);
		compares++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, s);
		end
	endtask
	task step;
		@(posedge clk_sys_i);
		#10;
	endtask
	task wr(input logic [21:0] a, input logic [15:0] v);
		step;
		wr_i = 1'b1;
		wr_word_i = {a, v};
		step;
		wr_i = 1'b0;
		st = pec_req_o.start;
		step;
		st = st | pec_req_o.start;
	endtask
	task poll;
		for (int i = 0; i < 60 && (pec_busy_i || status_o[0]); i++)
			step;
		// ready follows the state one edge after busy drops
		step;
	endtask
	// never the read-status code nor the terminator
	function logic [15:0] rnd;
		return {1'b0, 15'($urandom)} | 16'h0100;
	endfunction
	function logic [21:0] ex(int i);
		return (i == 5) ? w0 + 22'd20 : w0 + 22'(i);
	endfunction
	task dbl;
		d[0] = rnd();
		d[1] = rnd();
		wr(wb, {8'h00, `FPS_CMD_DOUBLE});
		wr(w0, d[0]);
		chk(st === 1'b0, "dbl early");
		wr(w0 + 22'd1, d[1]);
		chk(st === 1'b1 && page_word_o[1].data === d[1], "dbl");
	endtask
	initial begin
		{rst_i, rd_i} = 2'b11;
		{wr_i, suspend_req_i, fail_en} = 3'b000;
		rd_addr_i = w0;
		wr_word_i = '0;
		void'($urandom(32'h5501e670));
		repeat (3) @(posedge clk_sys_i);
		#10;
		rst_i = 1'b0;
		chk(status_o === 8'h80, "rst");
		dbl;
		suspend_req_i = 1'b1;
		m = read_mode_o;
		#1;
		chk(suspend_refused_o && rd_status_sel_o && !status_o[7], "busy");
		suspend_req_i = 1'b0;
		wr(wb, 16'h0050);
		chk(st === 1'b0 && read_mode_o === m, "ignore");
		poll;
		chk(status_o[7] === 1'b1, "dbl done");
		wr(wb, {8'h00, `FPS_CMD_QUAD});
		for (int i = 0; i < 4; i++) begin
			d[i] = rnd();
			wr(w0 + 22'(i), d[i]);
			chk(st === (i == 3), "quad");
		end
		for (int k = 0; k < 4; k++) begin
			chk(page_word_o[k].data === d[k], "slot");
			wr(wb, {8'h00, rc[k]});
			chk(read_mode_o === read_mode_t'(k) && rd_status_sel_o, "rd");
		end
		poll;
		// a single streamed run per block keeps the fast path
		wr(wb, {8'h00, `FPS_CMD_STREAM});
		wr(w0, {8'h00, `FPS_CMD_CONFIRM});
		chk(rd_status_sel_o === 1'b1 && st === 1'b0, "setup");
		for (int p = 0; p < 2; p++) begin
			fail_en = (p == 1);
			for (int i = 0; i < 6; i++) begin
				if (p == 0)
					d[i] = rnd();
				wr((i == 5) ? ex(5) : w0, d[i]);
				chk(st && pec_req_o.addr === ex(i) && pec_req_o.data === d[i]
					&& pec_req_o.verify === p[0], "word");
				poll;
			end
			wr(wx, 16'h1234);
			chk(st === 1'b0 && other_bank_block_o === 1'b1, "oob");
			wr(wx, `FPS_TERM_DATA);
			poll;
		end
		fail_en = 1'b0;
		chk(status_o[7] && status_o[4] && read_mode_o === rd_status, "exit");
		wr(wb, {8'h00, `FPS_CMD_PAGED});
		chk(rd_status_sel_o === 1'b1 && status_o[4] === 1'b0, "paged");
		for (int g = 0; g < 2; g++) begin
			for (int i = 0; i < 4; i++) begin
				d[i] = rnd();
				wr((i > 0) ? wx : w0 + 22'(g * 64), d[i]);
				if (g == 0 && i == 0)
					chk(status_o[7] === 1'b0, "accept");
			end
			chk(st && pec_req_o.verify && !status_o[7] && status_o[0], "pv");
			for (int k = 0; k < 4; k++)
				chk(page_word_o[k].data === d[k], "page");
			poll;
			chk(status_o[0] === 1'b0, "pv end");
		end
		wr(wx, `FPS_TERM_DATA);
		poll;
		chk(status_o === 8'h80 && !other_bank_block_o &&
			read_mode_o === rd_array, "p exit");
		dbl;
		rst_i = 1'b1;
		#1;
		chk(pec_req_o === '0 && other_bank_block_o === 1'b0, "abort");
		step;
		rst_i = 1'b0;
		dbl;
		poll;
		close_out;
	end
endmodule
bind flash_factory_program_sequencer fps_checker sva (
	.clk_sys_i, .rst_i, .wr_i, .wr_word_i, .rd_i, .rd_addr_i,
	.rd_status_sel_o, .read_mode_o, .pec_req_o, .pec_busy_i,
	.suspend_req_i, .suspend_refused_o, .other_bank_block_o, .status_o);
`default_nettype wire
